// ==== exc_unit.v ====
// Interrupt acknowledge sequencer and instruction trap detector.
`timescale 1ns/1ps
`default_nettype none
`include "exc_unit_consts.vh"

module exc_unit
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // Interrupt request pins, active low level
  input  wire [2:0]  irq_level_n,
  // Core status
  input  wire [2:0]  int_mask,
  input  wire        insn_done,
  // Bus answers from outside, active low
  input  wire        transfer_acknowledge_in_n,
  input  wire        peripheral_address_valid_n,
  input  wire        bus_error_n,
  input  wire [15:0] data_in,
  // Instruction check inputs, same clock domain
  input  wire        insn_valid,
  input  wire [15:0] insn_word,
  input  wire        insn_legal,
  input  wire        overflow_exception_op,
  input  wire        overflow_flag,
  input  wire        bounds_check_op,
  input  wire        bounds_violated,
  input  wire        signed_divide_op,
  input  wire        unsigned_divide_op,
  input  wire        divisor_zero,
  // Acknowledge bus outputs
  output reg  [2:0]  addr_level,
  output reg  [2:0]  function_code,
  output reg         address_strobe_n,
  output reg         upper_byte_strobe_n,
  output reg         lower_byte_strobe_n,
  // Exception result
  output reg         exc_valid,
  output reg  [7:0]  exc_vector,
  output reg  [2:0]  new_mask
);

  // Acknowledge sequencer states, one bus step each.
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_AS    = 3'h1;
  localparam [2:0] ST_DS    = 3'h2;
  localparam [2:0] ST_WAIT  = 3'h3;
  localparam [2:0] ST_DSOFF = 3'h4;
  localparam [2:0] ST_ASOFF = 3'h5;
  localparam [2:0] ST_LATCH = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Stage one feeds stage two only.
  reg [2:0] irq_s1_q;
  reg [2:0] irq_s2_q;
  // The third stage only remembers the previous synchronised level for the steadiness test.
  reg [2:0] irq_s3_q;
  reg       ack_s1_q;
  reg       ack_s2_q;
  reg       vpa_s1_q;
  reg       vpa_s2_q;
  reg       berr_s1_q;
  reg       berr_s2_q;
  reg [7:0] data_s1_q;
  reg [7:0] data_s2_q;

  // Reset values match released pins, so no false request or answer follows reset.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_s1_q  <= `IRQ_IDLE_N;
      irq_s2_q  <= `IRQ_IDLE_N;
      irq_s3_q  <= `IRQ_IDLE_N;
      ack_s1_q  <= 1'b1;
      ack_s2_q  <= 1'b1;
      vpa_s1_q  <= 1'b1;
      vpa_s2_q  <= 1'b1;
      berr_s1_q <= 1'b1;
      berr_s2_q <= 1'b1;
      data_s1_q <= 8'h00;
      data_s2_q <= 8'h00;
    end
    else
    begin
      irq_s1_q  <= irq_level_n;
      irq_s2_q  <= irq_s1_q;
      irq_s3_q  <= irq_s2_q;
      ack_s1_q  <= transfer_acknowledge_in_n;
      ack_s2_q  <= ack_s1_q;
      vpa_s1_q  <= peripheral_address_valid_n;
      vpa_s2_q  <= vpa_s1_q;
      berr_s1_q <= bus_error_n;
      berr_s2_q <= berr_s1_q;
      // Upper data byte ignored during vector fetch.
      // low byte only
      data_s1_q <= data_in[7:0];
      data_s2_q <= data_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt level qualification.
  // Each level pin crosses on its own, so a level change can pass through a
  // code that was never requested; a level counts only once two synchronised
  // samples agree, which costs one cycle of grant latency.
  wire       level_steady = (irq_s2_q == irq_s3_q);
  wire [2:0] req_level    = level_steady ? ~irq_s2_q : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Trap decoding.

  function [8:0] trap_decode;
    input [15:0] w;
    input        legal;
    input        ov_op;
    input        ov;
    input        bc_op;
    input        bc;
    input        ds_op;
    input        du_op;
    input        dz;
    begin
      trap_decode = 9'h000;
      // The order of the checks sets the priority when one word matches several.
      // unimplemented lines
      if (w[15:12] == `LINE_1010)
        trap_decode = {1'b1, `VEC_LINE_1010};
      else if (w[15:12] == `LINE_1111)
        trap_decode = {1'b1, `VEC_LINE_1111};
      else if (w == `OP_ILLEGAL_A || w == `OP_ILLEGAL_B || w == `OP_ILLEGAL_C)
        trap_decode = {1'b1, `VEC_ILLEGAL};
      else if (!legal)
        trap_decode = {1'b1, `VEC_ILLEGAL};
      else if ((w & `OP_SYSCALL_MASK) == `OP_SYSCALL_BITS)
        trap_decode = {1'b1, `VEC_SYSCALL_BASE + {4'h0, w[3:0]}};
      else if ((ds_op || du_op) && dz)
        trap_decode = {1'b1, `VEC_ZERO_DIVIDE};
      else if (bc_op && bc)
        trap_decode = {1'b1, `VEC_BOUNDS};
      else if (ov_op && ov)
        trap_decode = {1'b1, `VEC_OVERFLOW};
    end
  endfunction

  // Bit 8 flags a trap and bits 7:0 carry its vector.
  wire [8:0] trap = trap_decode(insn_word,
                                insn_legal,
                                overflow_exception_op,
                                overflow_flag,
                                bounds_check_op,
                                bounds_violated,
                                signed_divide_op,
                                unsigned_divide_op,
                                divisor_zero);

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge sequencer.
  reg [2:0] state_q;
  reg [2:0] level_q;

  // A slow responder may keep its answer low after the strobes drop. A new
  // acknowledge waits until all answers are released, so it cannot take the
  // previous cycle's answer as its own.
  wire       answers_idle = ack_s2_q && berr_s2_q && vpa_s2_q;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q             <= ST_IDLE;
      level_q             <= 3'h0;
      addr_level          <= 3'h0;
      function_code       <= 3'h0;
      address_strobe_n    <= 1'b1;
      upper_byte_strobe_n <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
      exc_valid           <= 1'b0;
      exc_vector          <= 8'h00;
      new_mask            <= 3'h0;
    end
    else
    begin
      // Pulse output: low unless a branch below ends an exception this cycle.
      exc_valid <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          // Level 7 is not maskable; equal levels are otherwise held off.
          // mask compare at boundary
          if (insn_done && answers_idle && req_level != 3'h0
              && (req_level > int_mask || req_level == 3'h7))
          begin
            level_q <= req_level;
            addr_level <= req_level;
            function_code <= `FC_INT_ACK;
            state_q <= ST_AS;
          end
          else if (insn_valid && trap[8])
          begin
            // Traps keep the current mask.
            exc_valid  <= 1'b1;
            exc_vector <= trap[7:0];
            new_mask   <= int_mask;
          end
        end
        ST_AS:
        begin
          address_strobe_n <= 1'b0;
          state_q          <= ST_DS;
        end
        ST_DS:
        begin
          upper_byte_strobe_n <= 1'b0;
          lower_byte_strobe_n <= 1'b0;
          state_q             <= ST_WAIT;
        end
        ST_WAIT:
        begin
          // With no answer at all the sequence waits here until bus error arrives.
          // Bus error wins over an autovector or vector answer seen in the same cycle.
          // spurious vector
          if (!berr_s2_q)
          begin
            exc_vector <= `VEC_SPURIOUS;
            state_q    <= ST_DSOFF;
          end
          // Autovector: the vector follows from the granted level and no data is read.
          else if (!vpa_s2_q)
          begin
            exc_vector <= `VEC_AUTO_BASE + {5'h00, level_q};
            state_q    <= ST_DSOFF;
          end
          else if (!ack_s2_q)
          begin
            // acquire vector, vector 15 passes as given
            state_q <= ST_LATCH;
          end
        end
        ST_LATCH:
        begin
          // The byte is read one cycle after the acknowledge was seen, so data that
          // changed together with the acknowledge has settled through both stages.
          // latch vector
          exc_vector <= data_s2_q;
          state_q    <= ST_DSOFF;
        end
        ST_DSOFF:
        begin
          upper_byte_strobe_n <= 1'b1;
          lower_byte_strobe_n <= 1'b1;
          state_q             <= ST_ASOFF;
        end
        ST_ASOFF:
        begin
          // The granted level becomes the mask, so equal levels stay held off.
          // address strobe last
          address_strobe_n <= 1'b1;
          function_code    <= 3'h0;
          addr_level       <= 3'h0;
          exc_valid        <= 1'b1;
          new_mask         <= level_q;
          state_q          <= ST_IDLE;
        end
        default:
        begin
          // Unused codes release the bus and return to idle rather than lock up.
          address_strobe_n    <= 1'b1;
          upper_byte_strobe_n <= 1'b1;
          lower_byte_strobe_n <= 1'b1;
          function_code       <= 3'h0;
          addr_level          <= 3'h0;
          state_q             <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // exc_unit
`default_nettype wire

// ==== exc_unit_consts.vh ====
// Constants for the interrupt acknowledge and trap logic.
`ifndef EXC_UNIT_CONSTS_VH
`define EXC_UNIT_CONSTS_VH
`define FC_INT_ACK        3'h7
`define IRQ_IDLE_N        3'h7
`define VEC_BUS_ERROR     8'h02
`define VEC_ILLEGAL       8'h04
`define VEC_ZERO_DIVIDE   8'h05
`define VEC_BOUNDS        8'h06
`define VEC_OVERFLOW      8'h07
`define VEC_LINE_1010     8'h0a
`define VEC_LINE_1111     8'h0b
`define VEC_UNINIT        8'h0f
`define VEC_SPURIOUS      8'h18
`define VEC_AUTO_BASE     8'h18
`define VEC_SYSCALL_BASE  8'h20
`define OP_ILLEGAL_A      16'h4afa
`define OP_ILLEGAL_B      16'h4afb
`define OP_ILLEGAL_C      16'h4afc
`define OP_SYSCALL_MASK   16'hfff0
`define OP_SYSCALL_BITS   16'h4e40
`define LINE_1010         4'ha
`define LINE_1111         4'hf
`endif

// ==== exc_unit_chk.sv ====
// Checker for the acknowledge strobes and trap outputs.
`timescale 1ns/1ps
`default_nettype none
module exc_unit_chk
(
  // Clock, reset and core status
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        insn_done,
  input wire logic        insn_valid,
  input wire logic [15:0] insn_word,
  // Unit outputs
  input wire logic [2:0]  function_code,
  input wire logic [2:0]  addr_level,
  input wire logic        address_strobe_n,
  input wire logic        upper_byte_strobe_n,
  input wire logic        lower_byte_strobe_n,
  input wire logic        exc_valid,
  input wire logic [7:0]  exc_vector,
  input wire logic [2:0]  new_mask
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Idle and not at a boundary, so no interrupt can outrank the trap.
  wire trap_ok = insn_valid && !insn_done && function_code == 3'h0;
  a_ack_fc_code: assert property (!address_strobe_n |-> function_code == 3'h7)
    else $error("fc not ack while strobed");
  a_as_level_set: assert property ($fell(address_strobe_n) |-> $stable(addr_level) && addr_level != 3'h0)
    else $error("level not on address");
  a_ds_inside_as: assert property (!upper_byte_strobe_n |-> !address_strobe_n)
    else $error("data strobe outside address strobe");
  a_both_strobes: assert property (upper_byte_strobe_n == lower_byte_strobe_n)
    else $error("data strobes differ");
  a_ds_after_as: assert property ($fell(address_strobe_n) |=> $fell(upper_byte_strobe_n))
    else $error("data strobes late");
  a_as_after_ds: assert property ($rose(upper_byte_strobe_n) |=> $rose(address_strobe_n) && exc_valid
    && new_mask == $past(addr_level))
    else $error("end of acknowledge wrong");
  a_reserved_word: assert property (trap_ok && insn_word == 16'h4afc |=> exc_valid && exc_vector == 8'h04)
    else $error("reserved word not illegal");
  a_line_f_trap: assert property (trap_ok && insn_word[15:12] == 4'hf |=> exc_valid && exc_vector == 8'h0b)
    else $error("line f vector wrong");
endmodule // exc_unit_chk
`default_nettype wire

// ==== periph_model.sv ====
// Interrupting peripheral with its bus error watchdog.
`timescale 1ns/1ps
`default_nettype none
module periph_model
(
  // Bus from the unit
  input  wire logic        ref_clk,
  input  wire logic [2:0]  function_code,
  input  wire logic        lower_byte_strobe_n,
  // Behaviour set by the bench: 0 vector, 1 autovector, 2 silent, 3 unprogrammed
  input  wire logic [1:0]  mode,
  input  wire logic [3:0]  delay,
  input  wire logic [7:0]  vector,
  // Answers to the unit
  output var  logic        transfer_acknowledge_in_n,
  output var  logic        peripheral_address_valid_n,
  output var  logic        bus_error_n,
  output var  logic [15:0] data_in
);
  logic [3:0] cnt;
  initial
  begin
    cnt = 4'h0;
    data_in = 16'h0000;
  end
  always @(posedge ref_clk)
  begin
    if (lower_byte_strobe_n || function_code != 3'h7)
    begin
      cnt <= 4'h0;
      transfer_acknowledge_in_n <= 1'b1;
      peripheral_address_valid_n <= 1'b1;
      bus_error_n <= 1'b1;
      // Released lines keep moving so stale data never looks valid.
      data_in <= ~data_in;
    end
    else if (cnt != delay)
      cnt <= cnt + 4'h1;
    else
    begin
      data_in <= {8'h5a, mode == 2'h3 ? 8'h0f : vector};
      transfer_acknowledge_in_n <= mode == 2'h1 || mode == 2'h2;
      peripheral_address_valid_n <= mode != 2'h1;
      bus_error_n <= mode != 2'h2;
    end
  end
endmodule // periph_model
`default_nettype wire

// ==== test_exc_unit.sv ====
// Self-checking bench for the exception unit.
`timescale 1ns/1ps
`default_nettype none
module test_exc_unit;
  logic ref_clk, rst_n, insn_done, insn_valid, insn_legal, exc_valid;
  logic address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n;
  logic transfer_acknowledge_in_n, peripheral_address_valid_n, bus_error_n;
  logic [2:0] irq_level_n, int_mask, addr_level, function_code, new_mask;
  logic [15:0] insn_word, data_in;
  logic [7:0] exc_vector, vector;
  logic [6:0] flags;
  logic [1:0] mode;
  logic [3:0] delay;
  int miscompares, tests_run, n;
  // Word, legal, {ov_op, ov, bc_op, bc, ds, du, dz}, {valid, vector}.
  logic [32:0] rows [12] = '{{16'ha123, 1'h1, 7'h00, 9'h10a}, {16'hf000, 1'h1, 7'h00, 9'h10b},
    {16'h4afa, 1'h1, 7'h00, 9'h104}, {16'h4afb, 1'h1, 7'h00, 9'h104}, {16'h4afc, 1'h1, 7'h00, 9'h104},
    {16'h4e71, 1'h0, 7'h00, 9'h104}, {16'h4e4f, 1'h1, 7'h00, 9'h12f}, {16'h81c0, 1'h1, 7'h05, 9'h105},
    {16'h80c0, 1'h1, 7'h03, 9'h105}, {16'h4180, 1'h1, 7'h18, 9'h106}, {16'h4e76, 1'h1, 7'h60, 9'h107},
    {16'h4e76, 1'h1, 7'h44, 9'h000}};
  exc_unit dut_u (.ref_clk, .rst_n, .irq_level_n, .int_mask, .insn_done, .transfer_acknowledge_in_n,
    .peripheral_address_valid_n, .bus_error_n, .data_in, .insn_valid, .insn_word, .insn_legal,
    .overflow_exception_op(flags[6]), .overflow_flag(flags[5]), .bounds_check_op(flags[4]),
    .bounds_violated(flags[3]), .signed_divide_op(flags[2]), .unsigned_divide_op(flags[1]),
    .divisor_zero(flags[0]), .addr_level, .function_code, .address_strobe_n, .upper_byte_strobe_n,
    .lower_byte_strobe_n, .exc_valid, .exc_vector, .new_mask);
  periph_model peer_u (.ref_clk, .function_code, .lower_byte_strobe_n, .mode, .delay, .vector,
    .transfer_acknowledge_in_n, .peripheral_address_valid_n, .bus_error_n, .data_in);
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  // Bounded wait for the acknowledge to start or for the exception pulse.
  task automatic wait_for(input logic ack);
    n = 0;
    while ((ack ? function_code !== 3'h7 : exc_valid !== 1'b1) && n < 40)
    begin
      tick(1);
      n++;
    end
    if (ack ? function_code !== 3'h7 : exc_valid !== 1'b1)
    begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic irq(input logic [2:0] lvl, input logic [2:0] msk, input logic [1:0] md, input logic [7:0] exp);
    int_mask = msk;
    mode = md;
    delay = {md, 2'h1};
    irq_level_n = ~lvl;
    tick(6);
    chk(function_code, 9'h000);
    insn_done = 1'b1;
    wait_for(1'b1);
    chk(addr_level, lvl);
    chk(function_code, 9'h007);
    irq_level_n = 3'h7;
    insn_done = 1'b0;
    wait_for(1'b0);
    chk(exc_vector, exp);
    chk(new_mask, lvl);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    {rst_n, insn_done, insn_valid, insn_legal, flags, insn_word, mode, delay} = '0;
    {irq_level_n, int_mask, vector} = {3'h7, 3'h2, 8'h40};
    tick(2);
    rst_n = 1'b1;
    tick(3);
    chk({address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, function_code, exc_valid}, 9'h070);
    foreach (rows[i])
    begin
      {insn_word, insn_legal, flags} = rows[i][32:9];
      insn_valid = 1'b1;
      tick(1);
      insn_valid = 1'b0;
      chk({exc_valid, rows[i][8] ? exc_vector : 8'h00}, rows[i][8:0]);
      chk(new_mask, 9'h002);
      tick(1);
    end
    irq(3'h5, 3'h2, 2'h0, 8'h40);
    irq(3'h3, 3'h0, 2'h1, 8'h1b);
    irq(3'h7, 3'h7, 2'h2, 8'h18);
    irq(3'h2, 3'h1, 2'h3, 8'h0f);
    // Equal level and mask must stay pending even at a boundary.
    {int_mask, irq_level_n, insn_done} = {3'h4, 3'h3, 1'b1};
    tick(8);
    chk(function_code, 9'h000);
    int_mask = 3'h3;
    wait_for(1'b1);
    tick(2);
    rst_n = 1'b0;
    tick(1);
    chk({address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, function_code, exc_valid}, 9'h070);
    // Release the mid-run reset with no request pending, then run one more acknowledge.
    {irq_level_n, insn_done} = {3'h7, 1'b0};
    rst_n = 1'b1;
    tick(3);
    chk({address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, function_code, exc_valid}, 9'h070);
    irq(3'h6, 3'h5, 2'h0, 8'h40);
    summarize();
  end
endmodule // test_exc_unit
bind exc_unit exc_unit_chk chk_u (.ref_clk, .rst_n, .insn_done, .insn_valid, .insn_word, .function_code,
  .addr_level, .address_strobe_n, .upper_byte_strobe_n, .lower_byte_strobe_n, .exc_valid, .exc_vector, .new_mask);
`default_nettype wire
